// ### rtl/cfa_rx_filter.sv
// Receive queue, receive buffer window and acceptance filter of a CAN controller.
// Assumes a bit stream processor on clk_in delivering header, data bytes and frame end,
// with data strobes at least one cycle after the header strobe; APB master on clk_in.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
module cfa_rx_filter #(
    parameter int DEPTH = cfa_pkg::FIFO_BYTES
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        hdr_valid_in,
    input  wire logic        hdr_ext_in,
    input  wire logic        hdr_rtr_in,
    input  wire logic [28:0] hdr_id_in,
    input  wire logic [3:0]  hdr_dlc_in,
    input  wire logic        data_valid_in,
    input  wire logic [7:0]  data_in,
    input  wire logic        frame_ok_in,
    input  wire logic        frame_abort_in,
    output logic             rx_avail_out,
    output logic             overrun_irq_out
);

    localparam int AW = $clog2(DEPTH);

    logic [7:0]  mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0]   used_r;
    logic [AW:0]   free_w;
    logic [4:0]  msg_cnt_r;
    logic [3:0]  wcnt_r;
    logic [3:0]  data_cnt_r;
    logic        ovf_r;
    logic        in_frame_r;
    logic        ext_r;
    logic        rtr_r;
    logic [28:0] id_r;
    logic [3:0]  dlc_r;
    logic [7:0]  d0_r;
    logic [7:0]  d1_r;
    logic [7:0]  mode_r;
    logic [7:0]  irq_en_r;
    logic        ovr_flag_r;
    logic [7:0]  code_r [0:3];
    logic [7:0]  mask_r [0:3];
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic [7:0]  hdr_byte [0:cfa_pkg::HDR_MAX-1];
    logic [3:0]  hdr_len;
    logic [5:0]  idx;
    logic        mapped;
    logic        wr_en;
    logic        release_w;
    logic [6:0]  rel_len;
    logic        commit_w;
    logic        overrun_evt;
    logic        data_ok_w;
    logic        single_sel;
    logic        accept_w;
    logic        single_match;
    logic        f1_match;
    logic        f2_match;
    logic [31:0] s_vec;
    logic [31:0] s_ign;
    logic [19:0] f1_vec;
    logic [19:0] f1_ign;
    logic [15:0] f2_vec;
    logic [15:0] f2_ign;
    logic        d0_present;
    logic        d1_present;
    logic [3:0]  ndata;

    // Free space and bus decode
    assign free_w    = (AW+1)'(DEPTH) - used_r;
    assign idx       = paddr_in[7:2];
    assign mapped    = (paddr_in[1:0] == 2'b00) &&
                       (idx == cfa_pkg::REG_MODE || idx == cfa_pkg::REG_CMD ||
                        idx == cfa_pkg::REG_STATUS || idx == cfa_pkg::REG_IRQ_EN ||
                        (idx >= cfa_pkg::REG_CODE_FIRST && idx <= cfa_pkg::REG_WIN_LAST));
    assign wr_en     = psel_in && penable_in && pwrite_in && mapped;
    assign release_w = wr_en && idx == cfa_pkg::REG_CMD &&
                       pwdata_in[cfa_pkg::CMD_RELEASE_BIT] && msg_cnt_r != 5'h00;
    assign rel_len   = cfa_pkg::msg_len(mem[rd_ptr_r]);
    assign single_sel = mode_r[cfa_pkg::MODE_FILTER_LAYOUT_BIT];

    // Header bytes laid out as the buffer window shows them
    always_comb begin
        hdr_byte[0] = {hdr_ext_in, hdr_rtr_in, 2'b00, hdr_dlc_in};
        hdr_byte[1] = hdr_id_in[28:21];
        if (hdr_ext_in) begin
            hdr_byte[2] = hdr_id_in[20:13];
            hdr_byte[3] = hdr_id_in[12:5];
            hdr_byte[4] = {hdr_id_in[4:0], hdr_rtr_in, 2'b00};
            hdr_len     = 4'(cfa_pkg::HDR_LEN_EFF);
        end else begin
            hdr_byte[2] = {hdr_id_in[20:18], hdr_rtr_in, 4'h0};
            hdr_byte[3] = 8'h00;
            hdr_byte[4] = 8'h00;
            hdr_len     = 4'(cfa_pkg::HDR_LEN_SFF);
        end
    end

    // Data byte taken only while in a frame and within eight; room is checked at the write
    assign data_ok_w = in_frame_r && data_valid_in && !hdr_valid_in &&
                       data_cnt_r < 4'(cfa_pkg::MAX_DATA_BYTES);

    // Queue storage writes; nothing beyond the free space is overwritten
    always_ff @(posedge clk_in) begin
        if (hdr_valid_in) begin
            for (int k = 0; k < cfa_pkg::HDR_MAX; k++) begin
                if (4'(k) < hdr_len && (AW+1)'(k) < free_w) begin
                    mem[wr_ptr_r + AW'(k)] <= hdr_byte[k];
                end
            end
        end else if (data_ok_w && (AW+1)'(wcnt_r) < free_w) begin
            mem[wr_ptr_r + AW'(wcnt_r)] <= data_in;
        end
    end

    // Frame capture and tentative write count
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            in_frame_r <= 1'b0;
            wcnt_r     <= 4'h0;
            data_cnt_r <= 4'h0;
            ovf_r      <= 1'b0;
            ext_r      <= 1'b0;
            rtr_r      <= 1'b0;
            id_r       <= 29'h0;
            dlc_r      <= 4'h0;
            d0_r       <= 8'h00;
            d1_r       <= 8'h00;
        end else if (hdr_valid_in) begin
            in_frame_r <= 1'b1;
            wcnt_r     <= hdr_len;
            data_cnt_r <= 4'h0;
            ovf_r      <= (AW+1)'(hdr_len) > free_w;
            ext_r      <= hdr_ext_in;
            rtr_r      <= hdr_rtr_in;
            id_r       <= hdr_id_in;
            dlc_r      <= hdr_dlc_in;
        end else if (frame_ok_in || frame_abort_in) begin
            in_frame_r <= 1'b0;
            wcnt_r     <= 4'h0;
            data_cnt_r <= 4'h0;
            ovf_r      <= 1'b0;
        end else if (data_ok_w) begin
            data_cnt_r <= data_cnt_r + 4'h1;
            if ((AW+1)'(wcnt_r) < free_w) begin
                wcnt_r <= wcnt_r + 4'h1;
            end else begin
                ovf_r <= 1'b1;
            end
            if (data_cnt_r == 4'h0) begin
                d0_r <= data_in;
            end
            if (data_cnt_r == 4'h1) begin
                d1_r <= data_in;
            end
        end
    end

    // Data bytes present in the frame, remote frames carry none
    always_comb begin
        ndata = (dlc_r > 4'(cfa_pkg::MAX_DATA_BYTES)) ? 4'(cfa_pkg::MAX_DATA_BYTES) : dlc_r;
        if (rtr_r) begin
            ndata = 4'h0;
        end
        d0_present = ndata != 4'h0 && data_cnt_r != 4'h0;
        d1_present = ndata > 4'h1 && data_cnt_r > 4'h1;
    end

    // Compared bit vectors, code byte zero meets identifier bit 28
    always_comb begin
        if (ext_r) begin
            s_vec  = {id_r, rtr_r, 2'b00};
            s_ign  = {30'h0, 2'b11};
            f1_vec = {id_r[28:13], 4'h0};
            f1_ign = {16'h0, 4'hF};
            f2_vec = id_r[28:13];
            f2_ign = 16'h0;
        end else begin
            s_vec  = {id_r[28:18], rtr_r, 4'h0, d0_r, d1_r};
            s_ign  = {12'h0, 4'hF, {8{!d0_present}}, {8{!d1_present}}};
            f1_vec = {id_r[28:18], rtr_r, d0_r};
            f1_ign = {12'h0, {8{!d0_present}}};
            f2_vec = {id_r[28:18], rtr_r, 4'h0};
            f2_ign = {12'h0, 4'hF};
        end
    end

    // Single long filter over all four code bytes
    cfa_bit_match #(.W(32)) u_single (
        .value_in    (s_vec),
        .code_in     ({code_r[0], code_r[1], code_r[2], code_r[3]}),
        .dontcare_in ({mask_r[0], mask_r[1], mask_r[2], mask_r[3]}),
        .ignore_in   (s_ign),
        .match_out   (single_match)
    );

    // Dual filter one, data byte split over low nibbles of bytes one and three
    cfa_bit_match #(.W(20)) u_dual1 (
        .value_in    (f1_vec),
        .code_in     ({code_r[0], code_r[1], code_r[3][3:0]}),
        .dontcare_in ({mask_r[0], mask_r[1], mask_r[3][3:0]}),
        .ignore_in   (f1_ign),
        .match_out   (f1_match)
    );

    // Dual filter two on code bytes two and three
    cfa_bit_match #(.W(16)) u_dual2 (
        .value_in    (f2_vec),
        .code_in     ({code_r[2], code_r[3]}),
        .dontcare_in ({mask_r[2], mask_r[3]}),
        .ignore_in   (f2_ign),
        .match_out   (f2_match)
    );

    // Layout select and commit decision at frame valid
    assign accept_w    = single_sel ? single_match : (f1_match || f2_match);
    assign commit_w    = frame_ok_in && in_frame_r && !hdr_valid_in && accept_w && !ovf_r;
    assign overrun_evt = frame_ok_in && in_frame_r && !hdr_valid_in && accept_w && ovf_r;

    // Queue pointers: a message counts only once committed
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr_r  <= '0;
            rd_ptr_r  <= '0;
            used_r    <= '0;
            msg_cnt_r <= 5'h00;
        end else begin
            if (commit_w) begin
                wr_ptr_r <= wr_ptr_r + AW'(wcnt_r);
            end
            if (release_w) begin
                rd_ptr_r <= rd_ptr_r + AW'(rel_len);
            end
            used_r <= used_r + (commit_w ? (AW+1)'(wcnt_r) : '0)
                             - (release_w ? (AW+1)'(rel_len) : '0);
            msg_cnt_r <= msg_cnt_r + (commit_w ? 5'h01 : 5'h00) - (release_w ? 5'h01 : 5'h00);
        end
    end

    // Overrun flag, a new overrun wins over a clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ovr_flag_r <= 1'b0;
        end else if (overrun_evt) begin
            ovr_flag_r <= 1'b1;
        end else if (wr_en && idx == cfa_pkg::REG_CMD && pwdata_in[cfa_pkg::CMD_CLR_OVR_BIT]) begin
            ovr_flag_r <= 1'b0;
        end
    end

    // Software configuration registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mode_r   <= cfa_pkg::MODE_RESET;
            irq_en_r <= 8'h00;
            for (int k = 0; k < 4; k++) begin
                code_r[k] <= cfa_pkg::CODE_RESET;
                mask_r[k] <= cfa_pkg::MASK_RESET;
            end
        end else if (wr_en) begin
            if (idx == cfa_pkg::REG_MODE) begin
                mode_r <= pwdata_in[7:0] & (8'h01 << cfa_pkg::MODE_FILTER_LAYOUT_BIT);
            end
            if (idx == cfa_pkg::REG_IRQ_EN) begin
                irq_en_r <= pwdata_in[7:0] & (8'h01 << cfa_pkg::IRQ_EN_OVERRUN_BIT);
            end
            for (int k = 0; k < 4; k++) begin
                if (idx == cfa_pkg::REG_CODE_FIRST + 6'(k)) begin
                    code_r[k] <= pwdata_in[7:0];
                end
                if (idx == cfa_pkg::REG_MASK_FIRST + 6'(k)) begin
                    mask_r[k] <= pwdata_in[7:0];
                end
            end
        end
    end

    // Read data captured in the setup cycle, shown in the access cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (psel_in && !penable_in) begin
            pslverr_r <= !mapped;
            prdata_r  <= 32'h0000_0000;
            if (mapped && !pwrite_in) begin
                if (idx == cfa_pkg::REG_MODE) begin
                    prdata_r[7:0] <= mode_r;
                end else if (idx == cfa_pkg::REG_IRQ_EN) begin
                    prdata_r[7:0] <= irq_en_r;
                end else if (idx == cfa_pkg::REG_STATUS) begin
                    prdata_r[cfa_pkg::STAT_RX_AVAIL_BIT] <= msg_cnt_r != 5'h00;
                    prdata_r[cfa_pkg::STAT_OVERRUN_BIT]  <= ovr_flag_r;
                end else if (idx >= cfa_pkg::REG_WIN_FIRST) begin
                    prdata_r[7:0] <= mem[rd_ptr_r + AW'(idx - cfa_pkg::REG_WIN_FIRST)];
                end else if (idx >= cfa_pkg::REG_MASK_FIRST) begin
                    prdata_r[7:0] <= mask_r[idx[1:0]];
                end else if (idx >= cfa_pkg::REG_CODE_FIRST) begin
                    prdata_r[7:0] <= code_r[idx[1:0]];
                end
            end
        end
    end

    // Bus answers and status outputs
    assign pready_out      = 1'b1;
    assign prdata_out      = prdata_r;
    assign pslverr_out     = pslverr_r && psel_in && penable_in;
    assign rx_avail_out    = msg_cnt_r != 5'h00;
    assign overrun_irq_out = ovr_flag_r && irq_en_r[cfa_pkg::IRQ_EN_OVERRUN_BIT];

    // Checks on the running design
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    AST_OVERRUN_FLAG: assert property (overrun_evt |=> ovr_flag_r)
        else $error("overrun event did not set the flag");
    AST_OVERRUN_DISCARD: assert property (overrun_evt |=> wr_ptr_r == $past(wr_ptr_r))
        else $error("overflowing message was kept");
    AST_OVERRUN_CAUSE: assert property (overrun_evt |-> ovf_r && accept_w)
        else $error("overrun without lack of space or acceptance");
    AST_USED_LIMIT: assert property (used_r <= (AW+1)'(DEPTH))
        else $error("queue holds more than its capacity");
    AST_REJECT_KEEP: assert property (frame_ok_in && in_frame_r && !accept_w |=>
                                      wr_ptr_r == $past(wr_ptr_r) && msg_cnt_r == $past(msg_cnt_r))
        else $error("rejected message was stored");
    AST_SINGLE_LAYOUT: assert property (single_sel |-> accept_w == single_match)
        else $error("single layout not used");
    AST_DUAL_EITHER: assert property (!single_sel && (f1_match || f2_match) |-> accept_w)
        else $error("dual filter hit not accepted");
    AST_DATA_LIMIT: assert property (data_cnt_r <= 4'(cfa_pkg::MAX_DATA_BYTES))
        else $error("more than eight data bytes taken");
    AST_DLC_KEPT: assert property (hdr_valid_in && free_w != '0 |=>
                                   mem[$past(wr_ptr_r)][3:0] == $past(hdr_dlc_in))
        else $error("length code not stored as sent");
    AST_ID_TOP: assert property (hdr_valid_in && free_w > (AW+1)'(1) |=>
                                 mem[$past(wr_ptr_r) + AW'(1)] == $past(hdr_id_in[28:21]))
        else $error("identifier top byte misplaced");
    AST_COMMIT_GROW: assert property (commit_w && !release_w |=>
                                      used_r == $past(used_r) + (AW+1)'($past(wcnt_r)))
        else $error("committed message length wrong");

endmodule : cfa_rx_filter

// ### rtl/cfa_pkg.sv
// Package for the CAN receive queue and acceptance filter block.
// Assumes byte-wide message storage and a 32-bit APB register bus.
package cfa_pkg;

    // Receive queue geometry
    localparam int FIFO_BYTES     = 64;
    localparam int MAX_DATA_BYTES = 8;
    localparam int HDR_LEN_SFF    = 3;
    localparam int HDR_LEN_EFF    = 5;
    localparam int HDR_MAX        = 5;

    // Register indexes, byte address is four times the index
    localparam logic [5:0] REG_MODE            = 6'h00;
    localparam logic [5:0] REG_CMD             = 6'h01;
    localparam logic [5:0] REG_STATUS          = 6'h02;
    localparam logic [5:0] REG_IRQ_EN          = 6'h04;
    localparam logic [5:0] REG_CODE_FIRST      = 6'h08;
    localparam logic [5:0] REG_MASK_FIRST      = 6'h0C;
    localparam logic [5:0] REG_WIN_FIRST       = 6'h10;
    localparam logic [5:0] REG_RX_EXT_ID_BYTE1 = 6'h11;
    localparam logic [5:0] REG_RX_EXT_ID_BYTE2 = 6'h12;
    localparam logic [5:0] REG_RX_EXT_ID_BYTE3 = 6'h13;
    localparam logic [5:0] REG_RX_EXT_ID_BYTE4 = 6'h14;
    localparam logic [5:0] REG_WIN_LAST        = 6'h1C;

    // Field positions
    localparam int MODE_FILTER_LAYOUT_BIT = 3;
    localparam int CMD_RELEASE_BIT        = 2;
    localparam int CMD_CLR_OVR_BIT        = 3;
    localparam int STAT_RX_AVAIL_BIT      = 0;
    localparam int STAT_OVERRUN_BIT       = 1;
    localparam int IRQ_EN_OVERRUN_BIT     = 3;
    localparam int INFO_FF_BIT            = 7;
    localparam int INFO_RTR_BIT           = 6;

    // Reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CODE_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'hFF;

    // Bytes held by one message, from its frame information byte
    function automatic logic [6:0] msg_len(input logic [7:0] info);
        logic [6:0] ndata;
        ndata = 7'(info[3:0]);
        if (ndata > 7'(MAX_DATA_BYTES)) begin
            ndata = 7'(MAX_DATA_BYTES);
        end
        if (info[INFO_RTR_BIT]) begin
            ndata = 7'h00;
        end
        msg_len = (info[INFO_FF_BIT] ? 7'(HDR_LEN_EFF) : 7'(HDR_LEN_SFF)) + ndata;
    endfunction : msg_len

endpackage : cfa_pkg

// ### rtl/cfa_bit_match.sv
// Masked comparison of a message bit vector against acceptance code bits.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/100ps
module cfa_bit_match #(
    parameter int W = 32
) (
    input  wire logic [W-1:0] value_in,
    input  wire logic [W-1:0] code_in,
    input  wire logic [W-1:0] dontcare_in,
    input  wire logic [W-1:0] ignore_in,
    output logic              match_out
);

    // Every position either equals its code bit, is a don't-care or is ignored
    assign match_out = &((~(value_in ^ code_in)) | dontcare_in | ignore_in);

endmodule : cfa_bit_match

// ### test/cfa_host_model.sv
// Host model: APB master issuing one register transfer at a time.
// Assumes a slave on the same clock; the bench orders the transfers.
`timescale 1ns/100ps
module cfa_host_model (
    input  wire logic        clk_in,
    input  wire logic        pready_in,
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic [7:0]       paddr_out,
    output logic [31:0]      pwdata_out
);
    // Idle bus at time zero
    initial begin
        psel_out    = 1'b0;
        penable_out = 1'b0;
        pwrite_out  = 1'b0;
        paddr_out   = 8'h00;
        pwdata_out  = 32'h0000_0000;
    end

    // Setup cycle, then access held until ready is sampled high
    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        @(posedge clk_in);
        psel_out    <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out  <= wr;
        paddr_out   <= {idx, 2'b00};
        pwdata_out  <= {24'h00_0000, wd};
        @(posedge clk_in);
        penable_out <= 1'b1;
        @(posedge clk_in);
        while (pready_in !== 1'b1) begin
            @(posedge clk_in);
        end
        psel_out    <= 1'b0;
        penable_out <= 1'b0;
        pwdata_out  <= ~pwdata_out;  // Stale data not left looking valid
    endtask : xfer
endmodule : cfa_host_model

// ### test/cfa_rx_filter_bench.sv
// Bench for the receive queue and acceptance filter: frames, filters, overrun.
// Assumes the host model drives APB; frame link is driven here.
`timescale 1ns/100ps
module cfa_rx_filter_bench;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, rx_avail, ovr_irq;
    logic        hdr_valid, hdr_ext, hdr_rtr, data_valid, frame_ok, frame_abort;
    logic [7:0]  paddr, data_b;
    logic [31:0] pwdata, prdata;
    logic [28:0] hdr_id, id;
    logic [3:0]  hdr_dlc;
    logic [7:0]  dat [0:8];
    logic [32:0] exp_q [$];
    int          fail_count, samples_checked;

    cfa_rx_filter #(.DEPTH(cfa_pkg::FIFO_BYTES)) cfa_rx_filter_inst (
        .clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .hdr_valid_in(hdr_valid), .hdr_ext_in(hdr_ext), .hdr_rtr_in(hdr_rtr),
        .hdr_id_in(hdr_id), .hdr_dlc_in(hdr_dlc), .data_valid_in(data_valid), .data_in(data_b),
        .frame_ok_in(frame_ok), .frame_abort_in(frame_abort), .rx_avail_out(rx_avail),
        .overrun_irq_out(ovr_irq));
    cfa_host_model cfa_host_model_inst (.clk_in(clk), .pready_in(pready), .psel_out(psel),
        .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));

    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        finish_test();
    end

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // Completed reads compared against the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) begin
            check("read", {pslverr, prdata}, exp_q.pop_front());
        end
    end

    task automatic rd(input logic [5:0] idx, input logic [7:0] e);
        exp_q.push_back({1'b0, 24'h00_0000, e});
        cfa_host_model_inst.xfer(1'b0, idx, 8'h00);
    endtask : rd

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        cfa_host_model_inst.xfer(1'b1, idx, d);
    endtask : wr

    // Header, n data bytes, then frame end or abort
    task automatic frame(input logic ext, input logic rtr, input logic [3:0] dlc, input int n, input logic ok);
        @(posedge clk);
        hdr_valid <= 1'b1;
        hdr_ext   <= ext;
        hdr_rtr   <= rtr;
        hdr_id    <= id;
        hdr_dlc   <= dlc;
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            hdr_valid  <= 1'b0;
            data_valid <= 1'b1;
            data_b     <= dat[k];
        end
        @(posedge clk);
        hdr_valid   <= 1'b0;
        data_valid  <= 1'b0;
        frame_ok    <= ok;
        frame_abort <= !ok;
        @(posedge clk);
        frame_ok    <= 1'b0;
        frame_abort <= 1'b0;
    endtask : frame

    // Program filter, send a frame, check acceptance and stored header
    task automatic tc(input logic [7:0] mode, input logic ext, input logic rtr, input logic [3:0] dlc,
                      input int n, input logic [31:0] code, input logic [31:0] mask, input logic acc);
        wr(cfa_pkg::REG_MODE, mode);
        for (int b = 0; b < 4; b++) begin
            wr(cfa_pkg::REG_CODE_FIRST + 6'(b), code[31-8*b -: 8]);
            wr(cfa_pkg::REG_MASK_FIRST + 6'(b), mask[31-8*b -: 8]);
        end
        frame(ext, rtr, dlc, n, 1'b1);
        rd(cfa_pkg::REG_STATUS, {7'h00, acc});
        check("rx_avail", 33'(rx_avail), 33'(acc));
        if (acc) begin
            rd(cfa_pkg::REG_WIN_FIRST, {ext, rtr, 2'b00, dlc});
            if (ext) begin
                rd(cfa_pkg::REG_RX_EXT_ID_BYTE4, {id[4:0], rtr, 2'b00});
            end
            wr(cfa_pkg::REG_CMD, 8'h04);
        end
    endtask : tc

    // Main sequence
    initial begin
        {psel, hdr_valid, hdr_ext, hdr_rtr, data_valid, frame_ok, frame_abort} = 7'h00;
        {hdr_id, hdr_dlc, data_b, fail_count, samples_checked} = '0;
        rst = 1'b1;
        void'($urandom(32'h166631b7));
        id = 29'($urandom());
        for (int k = 0; k < 9; k++) begin
            dat[k] = 8'($urandom());
        end
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(cfa_pkg::REG_MODE, cfa_pkg::MODE_RESET);
        rd(cfa_pkg::REG_CODE_FIRST, cfa_pkg::CODE_RESET);
        rd(cfa_pkg::REG_MASK_FIRST, cfa_pkg::MASK_RESET);
        exp_q.push_back({1'b1, 32'h0000_0000});
        cfa_host_model_inst.xfer(1'b0, 6'h03, 8'h00);
        frame(1'b1, 1'b0, 4'h2, 2, 1'b0);
        rd(cfa_pkg::REG_STATUS, 8'h00);
        frame(1'b1, 1'b0, 4'hA, 9, 1'b1);
        rd(cfa_pkg::REG_WIN_FIRST, 8'h8A);
        rd(cfa_pkg::REG_RX_EXT_ID_BYTE1, id[28:21]);
        rd(cfa_pkg::REG_RX_EXT_ID_BYTE2, id[20:13]);
        rd(cfa_pkg::REG_RX_EXT_ID_BYTE3, id[12:5]);
        rd(cfa_pkg::REG_RX_EXT_ID_BYTE4, {id[4:0], 3'b000});
        for (int k = 0; k < 8; k++) begin
            rd(6'h15 + 6'(k), dat[k]);
        end
        wr(cfa_pkg::REG_CMD, 8'h04);
        tc(8'h08, 1'b1, 1'b1, 4'h3, 0, {id, 1'b1, 2'b10}, 32'h0, 1'b1);
        tc(8'h08, 1'b1, 1'b0, 4'h0, 0, {id ^ 29'h0010_0000, 3'b000}, 32'h0, 1'b0);
        tc(8'h08, 1'b1, 1'b0, 4'h0, 0, {id ^ 29'h0010_0000, 3'b000}, 32'h0080_0000, 1'b1);
        tc(8'h08, 1'b0, 1'b0, 4'h1, 1, {id[28:18], 1'b0, 4'h5, dat[0], ~dat[1]}, 32'h0, 1'b1);
        tc(8'h08, 1'b0, 1'b0, 4'h1, 1, {id[28:18], 1'b0, 4'h5, ~dat[0], 8'h00}, 32'h0, 1'b0);
        tc(8'h00, 1'b0, 1'b0, 4'h1, 1, {id[28:18], 1'b0, ~dat[0][7:4], id[28:18], 1'b0, ~dat[0][3:0]},
           32'h0, 1'b1);
        tc(8'h00, 1'b0, 1'b0, 4'h1, 1, {id[28:18], 1'b0, ~dat[0][7:4], ~id[28:18], 1'b0, ~dat[0][3:0]},
           32'h0, 1'b0);
        tc(8'h00, 1'b0, 1'b0, 4'h1, 1, {id[28:18], 1'b0, ~dat[0][7:4], ~id[28:18], 1'b0, ~dat[0][3:0]},
           32'h000F_000F, 1'b1);
        tc(8'h00, 1'b0, 1'b1, 4'h2, 0, {id[28:18], 1'b1, 4'h0, ~id[28:18], 1'b1, 4'h0}, 32'h0, 1'b1);
        tc(8'h00, 1'b1, 1'b0, 4'h0, 0, {~id[28:13], id[28:13]}, 32'h0, 1'b1);
        tc(8'h00, 1'b1, 1'b0, 4'h0, 0, {~id[28:13], ~id[28:13]}, 32'h0, 1'b0);
        // Five 11-byte messages, one that cannot fit, then one that fills 64 exactly
        for (int b = 0; b < 4; b++) begin
            wr(cfa_pkg::REG_MASK_FIRST + 6'(b), 8'hFF);  // All don't care, every frame passes
        end
        wr(cfa_pkg::REG_IRQ_EN, 8'h08);
        for (int i = 0; i < 7; i++) begin
            frame(1'b0, 1'b0, (i == 6) ? 4'h6 : 4'h8, (i == 6) ? 6 : 8, 1'b1);
        end
        check("ovr_irq", 33'(ovr_irq), 33'h1);
        rd(cfa_pkg::REG_STATUS, 8'h03);
        for (int j = 0; j < 6; j++) begin
            rd(cfa_pkg::REG_WIN_FIRST, (j == 5) ? 8'h06 : 8'h08);
            wr(cfa_pkg::REG_CMD, 8'h04);
        end
        wr(cfa_pkg::REG_IRQ_EN, 8'h00);
        @(posedge clk);  // Enable register updates at the access edge
        check("ovr_irq", 33'(ovr_irq), 33'h0);
        wr(cfa_pkg::REG_CMD, 8'h08);
        rd(cfa_pkg::REG_STATUS, 8'h00);
        finish_test();
    end
endmodule : cfa_rx_filter_bench
